// [bench/mac_regs_assertions.sv]
/* Checker on the ports of mac_regs.
   Bound into every mac_regs instance; sees ports only. */
`timescale 1ns/1ns
module mac_chk
	import mac_pkg::*;
(
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] irq_status,
	input wire logic        backoff_tick,
	input wire logic        force_collision,
	input wire logic        mac_loopback,
	input wire logic        transceiver_loopback_sel,
	input wire logic [1:0]  rx_state,
	input wire logic        backoff_step,
	input wire logic        irq
);
	// Taken writes per register, and taken reads of the enable register
	wire wn = reg_wr & clk_en & reg_addr == MAC_OFS_NAC;
	wire wi = reg_wr & clk_en & reg_addr == MAC_OFS_IEM;
	wire ri = reg_rd & clk_en & reg_addr == MAC_OFS_IEM;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_fc_follow: assert property (wn |=> force_collision == $past(reg_wdata[12]))
		else $error("force collision wrong");
	a_mode_loop: assert property (wn |=>
		mac_loopback == ($past(reg_wdata[11:10]) == MAC_OM_MACLOOP))
		else $error("loopback mode wrong");
	a_xcvr_sel: assert property (transceiver_loopback_sel != mac_loopback)
		else $error("loopback select wrong");
	a_iem_back: assert property (wi ##1 !reg_wr ##1 ri |=>
		reg_rdata == ($past(reg_wdata, 3) & 32'h0001ABEF))
		else $error("enable readback wrong");
	a_rd_idle: assert property (!$past(reg_rd) && $past(clk_en) |->
		reg_rdata == 32'h0) else $error("read data not idle");
	a_rx_start: assert property (wn & reg_wdata[1] & rx_state == MAC_RX_STOP
		##1 clk_en |=> rx_state == MAC_RX_RUN) else $error("engine not run");
	a_irq_cause: assert property (irq |-> |(irq_status & 32'h00002BEF))
		else $error("irq without source");
	a_irq_groups: assert property (wi && reg_wdata[16:15] == 2'h0 |=> !irq)
		else $error("irq with groups off");
	a_step_gate: assert property (backoff_step |-> backoff_tick & clk_en)
		else $error("backoff step without tick");
	c_irq: cover property (irq);
	c_drain: cover property (rx_state == MAC_RX_DRAIN);
	c_step: cover property (backoff_step);
endmodule : mac_chk

bind mac_regs mac_chk u_chk (.*);

// [bench/tb_mac_mode_and_irq_enable_regs.sv]
/* Self-checking bench for mac_regs with a behavioural model.
   Assumes mac_pkg and the checker are compiled first. */
`timescale 1ns/1ns
module tb_mac_mode_and_irq_enable_regs
	import mac_pkg::*;
;
	logic        mclk = 0, resetn = 0, wr = 0, rd = 0;
	logic        cp = 0, bt = 0, inf = 0, eng = 0;
	logic        fc, ml, xs, acc, run, stp, irq;
	logic [1:0]  rs;
	logic [7:0]  addr = 0, p = 1;
	logic [31:0] wd = 0, st = 0, rdata, w;
	int          n_errors = 0, n_checks = 0, cyc = 0, i;
	int          nac = 32'h40, iem = 0;

	mac_regs dut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .irq_status(st), .rx_in_frame(inf),
		.rx_suspend_req(1'b0), .rx_pkt_valid(p[0]), .rx_pkt_mcast(p[1]),
		.rx_pkt_addr_hit(p[2]), .rx_pkt_bad(p[3]), .rx_pkt_pause(p[4]),
		.rx_pkt_wake(p[5]), .pause_en(p[6]), .wake_en(p[7]),
		.carrier_pin(cp), .backoff_tick(bt), .force_collision(fc),
		.mac_loopback(ml), .transceiver_loopback_sel(xs),
		.rx_accept(acc), .rx_running(run), .rx_state(rs),
		.backoff_step(stp), .irq(irq));

	// Clock and hang guard
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 5000) begin
			n_errors++;
			test_done();
		end
	end

	task test_done();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, s, e);
		end
	endtask : chk

	// Bus write; one idle edge after, so strobes never double up
	task wrt(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge mclk);
		wr <= 0;
		@(posedge mclk);
	endtask : wrt

	// Read data stand only in the cycle after the strobe
	task rdc(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		#1 chk(rdata, e);
		@(posedge mclk);
	endtask : rdc

	// Model: gated interrupt and receive filter
	function logic mirq(logic [31:0] s, logic [31:0] e);
		return |(s & e & 32'h45) & e[16] | |(s & e & 32'h2BAA) & e[15];
	endfunction : mirq

	function logic macc();
		return p[4] & p[6] | p[5] & p[7] | eng & (nac[6] | p[1] & nac[7]
			| p[2]) & (!p[3] | nac[3]);
	endfunction : macc

	initial begin
		void'($urandom(32'h65243B5C));
		repeat (16) @(posedge mclk);
		resetn <= 1;
		@(posedge mclk);
		rdc(MAC_OFS_NAC, 32'h40);
		rdc(MAC_OFS_IEM, 32'h0);
		rdc(8'h3C, 32'h0);
		chk(irq, 1'b0);
		$display("test reset done");
		for (i = 0; i < 24; i++) begin
			w = $urandom;
			wrt(MAC_OFS_IEM, w);
			iem = w & 32'h1ABEF;
			rdc(MAC_OFS_IEM, iem);
			@(posedge mclk);
			st <= $urandom & $urandom & $urandom;
			#1 chk(irq, mirq(st, iem));
		end
		$display("test irq done");
		// Filter and mode writes only while stopped
		for (i = 0; i < 12; i++) begin
			w = $urandom & ~32'h2;
			wrt(MAC_OFS_NAC, w);
			nac = w & 32'h1CEA;
			rdc(MAC_OFS_NAC, nac);
			chk({fc, ml, xs}, {w[12], w[11:10] == 2'h1, w[11:10] != 2'h1});
			@(posedge mclk);
			p <= $urandom | 8'h01;
			cp <= $urandom;
			bt <= $urandom;
			repeat (3) @(posedge mclk);
			#1 chk({acc, stp}, {macc(), bt & !(nac[5] & cp)});
		end
		$display("test control done");
		nac = nac | 2;
		wrt(MAC_OFS_NAC, nac);
		eng = 1;
		rdc(MAC_OFS_NAC, nac);
		chk({rs, run}, 3'h3);
		for (i = 0; i < 16; i++) begin
			@(posedge mclk);
			p <= $urandom | 8'h01;
			#1 chk(acc, macc());
		end
		@(posedge mclk);
		inf <= 1;
		wrt(MAC_OFS_NAC, nac & ~2);
		rdc(MAC_OFS_NAC, nac & ~2);
		chk(rs, MAC_RX_DRAIN);
		@(posedge mclk);
		inf <= 0;
		repeat (2) @(posedge mclk);
		#1 chk(rs, MAC_RX_STOP);
		$display("test engine done");
		test_done();
	end
endmodule : tb_mac_mode_and_irq_enable_regs

// [hw/mac_pkg.sv]
/*
 * Package for the MAC mode and interrupt enable register block:
 * register offsets, field positions, reset values and engine states.
 * Assumes a byte-addressed register port with 32-bit words.
 */
package mac_pkg;

	localparam logic [7:0]  MAC_OFS_NAC      = 8'h30;
	localparam logic [7:0]  MAC_OFS_IEM      = 8'h38;
	localparam logic [7:0]  MAC_OFS_ISW      = 8'h28;

	localparam int          MAC_NAC_FC       = 12;
	localparam int          MAC_NAC_OM_LO    = 10;
	localparam int          MAC_NAC_MM       = 7;
	localparam int          MAC_NAC_PR       = 6;
	localparam int          MAC_NAC_SBC      = 5;
	localparam int          MAC_NAC_PB       = 3;
	localparam int          MAC_NAC_SR       = 1;
	localparam logic [31:0] MAC_NAC_MASK     = 32'h00001CEA;
	localparam logic [31:0] MAC_NAC_RESET    = 32'h00000040;

	localparam int          MAC_IEM_NIE      = 16;
	localparam int          MAC_IEM_AIE      = 15;
	localparam logic [31:0] MAC_IEM_MASK     = 32'h0001ABEF;
	localparam logic [31:0] MAC_IEM_RESET    = 32'h00000000;
	localparam int          MAC_NSRC         = 11;

	localparam logic [1:0]  MAC_OM_NORMAL    = 2'h0;
	localparam logic [1:0]  MAC_OM_MACLOOP   = 2'h1;

	typedef enum logic [1:0] {
		MAC_RX_STOP    = 2'b00,
		MAC_RX_RUN     = 2'b01,
		MAC_RX_SUSP    = 2'b10,
		MAC_RX_DRAIN   = 2'b11
	} mac_rx_e;

endpackage : mac_pkg

// [hw/mac_regs.sv]
/*
 * Network access control and interrupt enable registers of the MAC,
 * with receive engine start/stop, filter controls and interrupt gating.
 * Assumes status flags arrive latched from the status block on mclk.
 */
// Notes on behaviour
// - force collision bit forces transmit collisions
// - mode 00 normal, 01 MAC loopback
// - all-multicast bit accepts every good multicast packet
// - promiscuous bit, reset one, accepts good packets
// - carrier gate pauses back-off while carrier
// - pass-bad bit keeps filtered bad packets
// - start bit runs engine; clear stops after frame
// - stopped engine still takes pause, wake frames
// - normal group enable gates normal sources
// - abnormal group enable gates abnormal sources
// - bus fault needs own and abnormal enable
// - timer expiry needs own and abnormal enable
// - rx watchdog needs own and abnormal enable
// - rx stopped needs own and abnormal enable
// - rx descriptor unavailable needs own and abnormal enable
// - rx done needs own and normal enable
// - tx underflow needs own and abnormal enable
// - tx jabber needs own and abnormal enable
// - tx done needs own and normal enable
// - tx stopped needs own and abnormal enable
// - tx descriptor unavailable needs own and normal enable
`timescale 1ns/1ns
module mac_regs
	import mac_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [31:0] irq_status,
	input  wire logic        rx_in_frame,
	input  wire logic        rx_suspend_req,
	input  wire logic        rx_pkt_valid,
	input  wire logic        rx_pkt_mcast,
	input  wire logic        rx_pkt_addr_hit,
	input  wire logic        rx_pkt_bad,
	input  wire logic        rx_pkt_pause,
	input  wire logic        rx_pkt_wake,
	input  wire logic        pause_en,
	input  wire logic        wake_en,
	input  wire logic        carrier_pin,
	input  wire logic        backoff_tick,
	output logic             force_collision,
	output logic             mac_loopback,
	output logic             transceiver_loopback_sel,
	output logic             rx_accept,
	output logic             rx_running,
	output logic [1:0]       rx_state,
	output logic             backoff_step,
	output logic             irq
);

	logic [31:0] nac_r;
	logic [31:0] iem_r;
	logic [31:0] rdata_r;
	mac_rx_e     rx_r;
	mac_rx_e     rx_nxt;
	logic        carr_s1_r;
	logic        carr_s2_r;
	logic        wr_nac;
	logic        wr_iem;
	logic        filt_ok;
	logic        engine_ok;
	logic [MAC_NSRC-1:0] gated;

	assign wr_nac = clk_en && reg_wr && (reg_addr == MAC_OFS_NAC);
	assign wr_iem = clk_en && reg_wr && (reg_addr == MAC_OFS_IEM);

	// Control word; only documented fields are stored
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			nac_r <= MAC_NAC_RESET;
		end else if (wr_nac) begin
			nac_r <= reg_wdata & MAC_NAC_MASK;
		end
	end

	// Enable word; reserved positions never stick
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			iem_r <= MAC_IEM_RESET;
		end else if (wr_iem) begin
			iem_r <= reg_wdata & MAC_IEM_MASK;
		end
	end

	// Engine next state; a stop waits for the current frame to end
	always_comb begin
		rx_nxt = rx_r;
		case (rx_r)
			MAC_RX_STOP: begin
				if (nac_r[MAC_NAC_SR]) begin
					rx_nxt = MAC_RX_RUN;
				end
			end
			MAC_RX_RUN: begin
				if (!nac_r[MAC_NAC_SR]) begin
					rx_nxt = rx_in_frame ? MAC_RX_DRAIN
						: MAC_RX_STOP;
				end else if (rx_suspend_req) begin
					rx_nxt = MAC_RX_SUSP;
				end
			end
			MAC_RX_SUSP: begin
				if (!nac_r[MAC_NAC_SR]) begin
					rx_nxt = rx_in_frame ? MAC_RX_DRAIN
						: MAC_RX_STOP;
				end else if (!rx_suspend_req) begin
					rx_nxt = MAC_RX_RUN;
				end
			end
			MAC_RX_DRAIN: begin
				if (!rx_in_frame) begin
					rx_nxt = nac_r[MAC_NAC_SR] ? MAC_RX_RUN
						: MAC_RX_STOP;
				end
			end
			default: rx_nxt = MAC_RX_STOP;
		endcase
	end

	// Engine state register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rx_r <= MAC_RX_STOP;
		end else if (clk_en) begin
			rx_r <= rx_nxt;
		end
	end

	// Carrier comes from a pin, so two flops before use
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			carr_s1_r <= 1'b0;
			carr_s2_r <= 1'b0;
		end else if (clk_en) begin
			carr_s1_r <= carrier_pin;
			carr_s2_r <= carr_s1_r;
		end
	end

	// Back-off advance, held while carrier when gated
	assign backoff_step = backoff_tick && clk_en &&
		!(nac_r[MAC_NAC_SBC] && carr_s2_r);

	assign force_collision = nac_r[MAC_NAC_FC];
	// Loopback overrides the transceiver's own loopback choice
	assign mac_loopback = (nac_r[MAC_NAC_OM_LO+1:MAC_NAC_OM_LO]
		== MAC_OM_MACLOOP);
	assign transceiver_loopback_sel = !mac_loopback;
	assign rx_state   = rx_r;
	assign rx_running = (rx_r != MAC_RX_STOP);

	// Address filter: promiscuous, all multicast or a hit
	assign filt_ok = nac_r[MAC_NAC_PR]
		|| (rx_pkt_mcast && nac_r[MAC_NAC_MM])
		|| rx_pkt_addr_hit;
	// Frames already in flight finish even when draining
	assign engine_ok = (rx_r == MAC_RX_RUN) || (rx_r == MAC_RX_DRAIN);

	// Acceptance; the settings are assumed to change only while stopped
	// Filtered bad frames need the pass-bad bit; full set also needs PR
	always_comb begin
		rx_accept = 1'b0;
		if (rx_pkt_valid) begin
			if ((rx_pkt_pause && pause_en) || (rx_pkt_wake && wake_en)) begin
				rx_accept = 1'b1;
			end else if (engine_ok && filt_ok) begin
				rx_accept = !rx_pkt_bad || nac_r[MAC_NAC_PB];
			end
		end
	end

	// Per-source gating: own enable and group enable, one per source
	genvar gi;
	generate
		for (gi = 0; gi < MAC_NSRC; gi++) begin : g_src
			logic [4:0] pos;
			logic       nrm;
			mac_src_map u_map (
				.idx       (4'(gi)),
				.bitpos    (pos),
				.is_normal (nrm)
			);
			// Normal and abnormal groups
			assign gated[gi] = irq_status[pos] && iem_r[pos] &&
				(nrm ? iem_r[MAC_IEM_NIE] : iem_r[MAC_IEM_AIE]);
		end
	endgenerate

	// Interrupt follows register state with no added delay
	assign irq = |gated;

	// Read port; unmapped addresses answer zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata_r <= 32'h00000000;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					MAC_OFS_NAC: rdata_r <= nac_r;
					MAC_OFS_IEM: rdata_r <= iem_r;
					default:     rdata_r <= 32'h00000000;
				endcase
			end else begin
				rdata_r <= 32'h00000000;
			end
		end
	end

	assign reg_rdata = rdata_r;

endmodule : mac_regs

// [hw/mac_src_map.sv]
/*
 * Table of interrupt sources: for each source its enable bit in the
 * mask register and whether the normal group gates it.
 * Assumes the caller indexes sources 0 to 10.
 */
`timescale 1ns/1ns
module mac_src_map
	import mac_pkg::*;
(
	input  wire logic [3:0] idx,
	output logic      [4:0] bitpos,
	output logic            is_normal
);

	// Constant lookup; cheaper than per-source parameters
	always_comb begin
		bitpos    = 5'h00;
		is_normal = 1'b0;
		case (idx)
			4'h0: begin bitpos = 5'h00; is_normal = 1'b1; end
			4'h1: bitpos = 5'h01;
			4'h2: begin bitpos = 5'h02; is_normal = 1'b1; end
			4'h3: bitpos = 5'h03;
			4'h4: bitpos = 5'h05;
			4'h5: begin bitpos = 5'h06; is_normal = 1'b1; end
			4'h6: bitpos = 5'h07;
			4'h7: bitpos = 5'h08;
			4'h8: bitpos = 5'h09;
			4'h9: bitpos = 5'h0B;
			4'hA: bitpos = 5'h0D;
			default: bitpos = 5'h00;
		endcase
	end

endmodule : mac_src_map
